// file: coc_top.sv
// clock output channel configuration: serial-loaded registers, gating and five channels
// Operation
// - five channel registers, index N drives channel N
// - divide by twice code, zero code invalid
// - bypass passes clock only with even post-divide
// - drive is channel bit AND global bit AND pin
// - gate pin defaults high, channel bits then rule
// - gate pin low forces every output low
// - global bit zero turns all outputs off
// - only channel 2 on after reset
// - channel 2 starts dividing by 12, post-divide 2
// - delay code times 150 ps, up to 2.25 ns
// - delay path adds fixed 300 ps
// - two-bit cmos state per leg
// - swing select: 0 standard, 1 raised
// - source select: bypass, divided, delayed, both
// - soft reset bit restores defaults, clears itself
// - global bit 18 of register 13, default on
`timescale 1ns/100ps
module coc_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_prog_clk,
  input wire logic i_prog_data,
  input wire logic i_prog_latch,
  input wire logic i_global_output_gate_pin,
  input wire logic i_dist_clk,
  output logic [coc_pkg::NUM_CH-1:0] o_output_channel,
  output logic [coc_pkg::NUM_CH-1:0] o_channel_drive,
  output logic [coc_pkg::NUM_CH-1:0] o_true_leg,
  output logic [coc_pkg::NUM_CH-1:0] o_true_leg_oe,
  output logic [coc_pkg::NUM_CH-1:0] o_comp_leg,
  output logic [coc_pkg::NUM_CH-1:0] o_comp_leg_oe,
  output logic [coc_pkg::NUM_CH-1:0] o_high_swing_pecl,
  output logic [coc_pkg::NUM_CH-1:0] o_delay_path_on,
  output logic [coc_pkg::NUM_CH-1:0][coc_pkg::DLY_PS_W-1:0] o_channel_delay_ps
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic gate_s1;
    logic gate_s2;
    logic dist_s1;
    logic dist_s2;
    logic dist_prev;
    coc_pkg::coc_chan_cfg_s [coc_pkg::NUM_CH-1:0] chan;
    logic all_outputs_on;
    logic [coc_pkg::VCO_DIV_W-1:0] vco_div;
    logic [coc_pkg::NUM_CH-1:0] drive;
    logic [coc_pkg::NUM_CH-1:0] clk_out;
    logic [coc_pkg::NUM_CH-1:0] true_leg;
    logic [coc_pkg::NUM_CH-1:0] true_oe;
    logic [coc_pkg::NUM_CH-1:0] comp_leg;
    logic [coc_pkg::NUM_CH-1:0] comp_oe;
    logic [coc_pkg::NUM_CH-1:0] swing;
    logic [coc_pkg::NUM_CH-1:0] dly_on;
    logic [coc_pkg::NUM_CH-1:0][coc_pkg::DLY_PS_W-1:0] dly_ps;
  } coc_top_s;

  coc_top_s s_reg;
  coc_top_s s_next;
  logic [coc_pkg::NUM_CH-1:0] div_clk;
  logic [coc_pkg::ADDR_W-1:0] wr_addr;
  logic soft_reset_hit;

  coc_word_if word_bus ();

  // power-on value; gate synchroniser starts high like the pulled-up pin
  function automatic coc_top_s rst_state();
    coc_top_s r;
    r = '0;
    r.gate_s1 = coc_pkg::GATE_RST;
    r.gate_s2 = coc_pkg::GATE_RST;
    r.chan = coc_pkg::CH_RST;
    r.all_outputs_on = coc_pkg::ALL_ON_RST;
    r.vco_div = coc_pkg::VCO_DIV_RST;
    return r;
  endfunction : rst_state

  // unpack one channel word; the bit positions are the same for every channel
  function automatic coc_pkg::coc_chan_cfg_s unpack_chan(input logic [coc_pkg::WORD_W-1:0] w);
    coc_pkg::coc_chan_cfg_s c;
    c.true_leg_cmos_state = w[coc_pkg::TRUE_LSB +: coc_pkg::LEG_W];
    c.comp_leg_cmos_state = w[coc_pkg::COMP_LSB +: coc_pkg::LEG_W];
    c.pecl_swing_select = w[coc_pkg::PECL_BIT];
    c.channel_source_select = w[coc_pkg::MUX_LSB +: coc_pkg::MUX_W];
    c.channel_output_on = w[coc_pkg::ON_BIT];
    c.channel_divide_code = w[coc_pkg::DIV_LSB +: coc_pkg::DIV_W];
    c.channel_delay_code = w[coc_pkg::DLY_LSB +: coc_pkg::DLY_W];
    return c;
  endfunction : unpack_chan

  // leg driver: returns {oe, level}; an off channel drives low unless floated
  function automatic logic [1:0] leg_drive(input logic [1:0] code, input logic clk, input logic on);
    logic [1:0] r;
    r = 2'h0;
    unique case (code)
      coc_pkg::LEG_INVERTED: r = {1'b1, on & ~clk};
      coc_pkg::LEG_NORMAL: r = {1'b1, on & clk};
      coc_pkg::LEG_LOW: r = 2'h2;
      coc_pkg::LEG_HIZ: r = 2'h0;
    endcase
    return r;
  endfunction : leg_drive

  // ----------------------------------------------------------------
  // serial programming port
  // ----------------------------------------------------------------
  coc_serial_rx u_rx (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_prog_clk(i_prog_clk),
    .i_prog_data(i_prog_data),
    .i_prog_latch(i_prog_latch),
    .o_word(word_bus)
  );

  // decode of the latched word
  assign wr_addr = word_bus.word[coc_pkg::ADDR_LSB +: coc_pkg::ADDR_W];
  assign soft_reset_hit = word_bus.valid && (wr_addr == coc_pkg::ADDR_SOFT_RESET) && word_bus.word[coc_pkg::SRST_BIT];

  // ----------------------------------------------------------------
  // channel dividers
  // ----------------------------------------------------------------
  // the divider runs from the registered drive, so gating also resets its phase
  for (genvar g = 0; g < coc_pkg::NUM_CH; g++) begin : g_chan
    coc_chan_div u_div (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_dist_rise(s_reg.dist_s2 & ~s_reg.dist_prev),
      .i_dist_level(s_reg.dist_s2),
      .i_enable(s_reg.drive[g]),
      .i_div_sel(s_reg.chan[g].channel_source_select[0]),
      .i_bypass_ok(~s_reg.vco_div[0]),
      .i_divide_code(s_reg.chan[g].channel_divide_code),
      .o_clk(div_clk[g])
    );
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // writes to reserved indices are ignored; their contents never steer anything
  always_comb begin
    s_next = s_reg;
    s_next.gate_s1 = i_global_output_gate_pin;
    s_next.gate_s2 = s_reg.gate_s1;
    s_next.dist_s1 = i_dist_clk;
    s_next.dist_s2 = s_reg.dist_s1;
    s_next.dist_prev = s_reg.dist_s2;
    if (soft_reset_hit) begin
      // the reset bit is not stored, so it reads back as its power-on zero
      s_next.chan = coc_pkg::CH_RST;
      s_next.all_outputs_on = coc_pkg::ALL_ON_RST;
      s_next.vco_div = coc_pkg::VCO_DIV_RST;
    end else if (word_bus.valid) begin
      if (wr_addr <= coc_pkg::ADDR_CH_LAST) begin
        s_next.chan[wr_addr[2:0]] = unpack_chan(word_bus.word);
      end else if (wr_addr == coc_pkg::ADDR_GLOBAL) begin
        s_next.all_outputs_on = word_bus.word[coc_pkg::ALL_ON_BIT];
      end else if (wr_addr == coc_pkg::ADDR_VCO) begin
        s_next.vco_div = word_bus.word[coc_pkg::VCO_DIV_LSB +: coc_pkg::VCO_DIV_W];
      end
    end
    for (int i = 0; i < coc_pkg::NUM_CH; i++) begin
      // three-way gate; any low term stops the channel
      s_next.drive[i] = s_reg.chan[i].channel_output_on & s_reg.all_outputs_on & s_reg.gate_s2;
      s_next.clk_out[i] = div_clk[i] & s_reg.drive[i];
      {s_next.true_oe[i], s_next.true_leg[i]} =
        leg_drive(s_reg.chan[i].true_leg_cmos_state, div_clk[i], s_reg.drive[i]);
      {s_next.comp_oe[i], s_next.comp_leg[i]} =
        leg_drive(s_reg.chan[i].comp_leg_cmos_state, div_clk[i], s_reg.drive[i]);
      s_next.swing[i] = s_reg.chan[i].pecl_swing_select;
      s_next.dly_on[i] = s_reg.chan[i].channel_source_select[1];
      // the delay itself is analog; the block reports the lag it asks for
      if (s_reg.chan[i].channel_source_select[1]) begin
        s_next.dly_ps[i] = coc_pkg::DLY_PS_W'({8'h00, s_reg.chan[i].channel_delay_code} * coc_pkg::DLY_STEP_PS_V)
          + coc_pkg::DLY_FIXED_PS_V;
      end else begin
        s_next.dly_ps[i] = '0;
      end
    end
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_reg <= rst_state();
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_output_channel = s_reg.clk_out;
  assign o_channel_drive = s_reg.drive;
  assign o_true_leg = s_reg.true_leg;
  assign o_true_leg_oe = s_reg.true_oe;
  assign o_comp_leg = s_reg.comp_leg;
  assign o_comp_leg_oe = s_reg.comp_oe;
  assign o_high_swing_pecl = s_reg.swing;
  assign o_delay_path_on = s_reg.dly_on;
  assign o_channel_delay_ps = s_reg.dly_ps;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  AST_DRIVE_AND: assert property (
    !$past(i_rst) |-> o_channel_drive ==
      ($past({s_reg.chan[4].channel_output_on, s_reg.chan[3].channel_output_on, s_reg.chan[2].channel_output_on,
      s_reg.chan[1].channel_output_on, s_reg.chan[0].channel_output_on})
      & {coc_pkg::NUM_CH{$past(s_reg.all_outputs_on) & $past(s_reg.gate_s2)}})
  ) else $error("channel drive is not the and of its three terms");

  AST_PIN_LOW_ALL_OFF: assert property (
    $fell(s_reg.gate_s2) |=> (o_channel_drive == '0) ##1 (o_output_channel == '0)
  ) else $error("gate pin low did not stop every output");

  AST_PIN_LOW_LEGS_LOW: assert property (
    !s_reg.gate_s2 [*3] |-> ((o_true_leg | o_comp_leg | o_output_channel) == '0)
  ) else $error("a leg stayed high with the gate pin low");

  AST_GLOBAL_OFF: assert property (
    !s_reg.all_outputs_on |=> (o_channel_drive == '0)
  ) else $error("global bit zero left a channel driven");

  AST_RESET_DEFAULT_ON: assert property (
    $past(i_rst) && !i_rst |-> ##1 (o_channel_drive == coc_pkg::ON_RST_MASK) || !$past(s_reg.gate_s2)
  ) else $error("channel enables after reset are not the start-up set");

  AST_START_CLOCK: assert property (
    $past(i_rst) |-> (s_reg.chan[2].channel_divide_code == 8'h06) && (s_reg.vco_div == coc_pkg::VCO_DIV_RST)
  ) else $error("start-up channel not set to divide by twelve");

  AST_DELAY_VALUE: assert property (
    s_reg.chan[0].channel_source_select[1] |=>
      (o_channel_delay_ps[0] == 12'($past(s_reg.chan[0].channel_delay_code)) * 12'h096 + 12'h12c)
      && (o_channel_delay_ps[0] <= coc_pkg::DLY_MAX_PS_V + coc_pkg::DLY_FIXED_PS_V)
  ) else $error("reported delay of channel 0 is wrong");

  AST_SOFT_RESET: assert property (
    soft_reset_hit |=> (s_reg.chan == coc_pkg::CH_RST) && s_reg.all_outputs_on
      && (s_reg.vco_div == coc_pkg::VCO_DIV_RST)
  ) else $error("soft reset did not restore power-on values");

  AST_HOLD_WITHOUT_WORD: assert property (
    !word_bus.valid |=> $stable(s_reg.chan) && $stable(s_reg.all_outputs_on) && $stable(s_reg.vco_div)
  ) else $error("configuration changed without a latched word");

  AST_CHANNEL_WRITE: assert property (
    (word_bus.valid && !soft_reset_hit && wr_addr == 4'h3) |=>
      (s_reg.chan[3].channel_divide_code == $past(word_bus.word[coc_pkg::DIV_LSB +: coc_pkg::DIV_W]))
      && $stable(s_reg.chan[2])
  ) else $error("write to channel 3 missed or touched channel 2");

  AST_SWING: assert property (
    ##1 o_high_swing_pecl[1] == $past(s_reg.chan[1].pecl_swing_select)
  ) else $error("swing select not passed to channel 1");

  // per-channel copies, so a fault on any index is caught
  for (genvar c = 0; c < coc_pkg::NUM_CH; c++) begin : g_chk
    AST_OFF_QUIET: assert property (
      !o_channel_drive[c]
      |=> !o_output_channel[c]
      && !o_true_leg[c]
      && !o_comp_leg[c]
    ) else $error("undriven channel toggled");

    AST_TRUE_FLOAT: assert property (
      (s_reg.chan[c].true_leg_cmos_state == coc_pkg::LEG_HIZ)
      |=> !o_true_leg_oe[c]
    ) else $error("floated true leg enabled");

    AST_COMP_FLOAT: assert property (
      (s_reg.chan[c].comp_leg_cmos_state == coc_pkg::LEG_HIZ)
      |=> !o_comp_leg_oe[c]
    ) else $error("floated comp leg enabled");

    AST_TRUE_LOW: assert property (
      (s_reg.chan[c].true_leg_cmos_state == coc_pkg::LEG_LOW)
      |=> o_true_leg_oe[c]
      && !o_true_leg[c]
    ) else $error("true leg not driven low");

    AST_COMP_LOW: assert property (
      (s_reg.chan[c].comp_leg_cmos_state == coc_pkg::LEG_LOW)
      |=> o_comp_leg_oe[c]
      && !o_comp_leg[c]
    ) else $error("comp leg not driven low");

    // a normal leg copies the divider, an inverted one its complement
    AST_TRUE_NORMAL: assert property (
      (s_reg.chan[c].true_leg_cmos_state == coc_pkg::LEG_NORMAL)
      |=> o_true_leg[c] == ($past(div_clk[c]) & $past(s_reg.drive[c]))
    ) else $error("normal true leg off the clock");

    AST_COMP_INVERT: assert property (
      (s_reg.chan[c].comp_leg_cmos_state == coc_pkg::LEG_INVERTED)
      |=> o_comp_leg[c] == (!$past(div_clk[c]) & $past(s_reg.drive[c]))
    ) else $error("inverted comp leg off the clock");

    AST_NO_DELAY: assert property (
      !s_reg.chan[c].channel_source_select[1]
      |=> !o_delay_path_on[c]
      && (o_channel_delay_ps[c] == '0)
    ) else $error("delay reported off the delay path");

    AST_SWING_ALL: assert property (
      s_reg.chan[c].pecl_swing_select
      |=> o_high_swing_pecl[c]
    ) else $error("raised swing not passed on");
  end

endmodule : coc_top

// file: coc_pkg.sv
// shared constants, field layout and reset values of the clock output channel block
package coc_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH = 5;
  localparam int WORD_W = 32;
  localparam int BITCNT_W = 6;
  localparam logic [BITCNT_W-1:0] WORD_BITS = 6'h20;
  localparam logic [BITCNT_W-1:0] BITCNT_MAX = 6'h3f;

  // ----------------------------------------------------------------
  // programming word layout: register index in the low nibble
  // ----------------------------------------------------------------
  localparam int ADDR_LSB = 0;
  localparam int ADDR_W = 4;
  localparam int DLY_LSB = 4;
  localparam int DLY_W = 4;
  localparam int DIV_LSB = 8;
  localparam int DIV_W = 8;
  localparam int ON_BIT = 16;
  localparam int MUX_LSB = 17;
  localparam int MUX_W = 2;
  localparam int PECL_BIT = 19;
  localparam int COMP_LSB = 20;
  localparam int TRUE_LSB = 22;
  localparam int LEG_W = 2;
  localparam int SRST_BIT = 17;
  localparam int ALL_ON_BIT = 18;
  localparam int VCO_DIV_LSB = 22;
  localparam int VCO_DIV_W = 4;

  // register indices
  localparam logic [ADDR_W-1:0] ADDR_CH_LAST = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_SOFT_RESET = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_GLOBAL = 4'hd;
  localparam logic [ADDR_W-1:0] ADDR_VCO = 4'hf;

  // ----------------------------------------------------------------
  // field codes
  // ----------------------------------------------------------------
  localparam logic [MUX_W-1:0] MUX_BYPASS = 2'h0;
  localparam logic [MUX_W-1:0] MUX_DIVIDED = 2'h1;
  localparam logic [MUX_W-1:0] MUX_DELAYED = 2'h2;
  localparam logic [MUX_W-1:0] MUX_DIV_DLY = 2'h3;
  localparam logic [LEG_W-1:0] LEG_INVERTED = 2'h0;
  localparam logic [LEG_W-1:0] LEG_NORMAL = 2'h1;
  localparam logic [LEG_W-1:0] LEG_LOW = 2'h2;
  localparam logic [LEG_W-1:0] LEG_HIZ = 2'h3;
  localparam logic [DIV_W-1:0] DIV_INVALID = 8'h00;

  // ----------------------------------------------------------------
  // delay reporting, in picoseconds
  // ----------------------------------------------------------------
  localparam int DLY_PS_W = 12;
  localparam int DLY_STEP_PS = 150;
  localparam int DLY_FIXED_PS = 300;
  localparam int DLY_MAX_PS = 2250;
  localparam logic [DLY_PS_W-1:0] DLY_STEP_PS_V = DLY_PS_W'(DLY_STEP_PS);
  localparam logic [DLY_PS_W-1:0] DLY_FIXED_PS_V = DLY_PS_W'(DLY_FIXED_PS);
  localparam logic [DLY_PS_W-1:0] DLY_MAX_PS_V = DLY_PS_W'(DLY_MAX_PS);

  // ----------------------------------------------------------------
  // per-channel configuration and reset values
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [LEG_W-1:0] true_leg_cmos_state;
    logic [LEG_W-1:0] comp_leg_cmos_state;
    logic pecl_swing_select;
    logic [MUX_W-1:0] channel_source_select;
    logic channel_output_on;
    logic [DIV_W-1:0] channel_divide_code;
    logic [DLY_W-1:0] channel_delay_code;
  } coc_chan_cfg_s;

  localparam coc_chan_cfg_s CH_OFF_RST = '{LEG_NORMAL, LEG_NORMAL, 1'b0, MUX_DIVIDED, 1'b0, 8'h01, 4'h0};
  localparam coc_chan_cfg_s CH_START_RST = '{LEG_NORMAL, LEG_NORMAL, 1'b0, MUX_DIVIDED, 1'b1, 8'h06, 4'h0};
  localparam coc_chan_cfg_s [NUM_CH-1:0] CH_RST = {CH_OFF_RST, CH_OFF_RST, CH_START_RST, CH_OFF_RST, CH_OFF_RST};
  localparam logic [NUM_CH-1:0] ON_RST_MASK = 5'h04;
  localparam logic ALL_ON_RST = 1'b1;
  localparam logic [VCO_DIV_W-1:0] VCO_DIV_RST = 4'h2;
  localparam logic GATE_RST = 1'b1;

endpackage : coc_pkg

// file: coc_word_if.sv
// carrier of a fully received programming word from the serial receiver to the core
`timescale 1ns/100ps
interface coc_word_if;
  logic valid;
  logic [coc_pkg::WORD_W-1:0] word;
  modport src (output valid, output word);
  modport dst (input valid, input word);
endinterface : coc_word_if

// file: coc_serial_rx.sv
// serial programming port receiver: shifts bits in, hands over a word on the latch edge
`timescale 1ns/100ps
module coc_serial_rx (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_prog_clk,
  input wire logic i_prog_data,
  input wire logic i_prog_latch,
  coc_word_if.src o_word
);

  typedef struct packed {
    logic clk_s1;
    logic clk_s2;
    logic clk_prev;
    logic dat_s1;
    logic dat_s2;
    logic le_s1;
    logic le_s2;
    logic le_prev;
    logic [coc_pkg::WORD_W-1:0] shift;
    logic [coc_pkg::BITCNT_W-1:0] cnt;
    logic valid;
    logic [coc_pkg::WORD_W-1:0] word;
  } coc_rx_s;

  coc_rx_s s_reg;
  coc_rx_s s_next;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // pins are slow against i_clk; data and clock share equal sync delay so setup holds
  always_comb begin
    s_next = s_reg;
    s_next.clk_s1 = i_prog_clk;
    s_next.clk_s2 = s_reg.clk_s1;
    s_next.clk_prev = s_reg.clk_s2;
    s_next.dat_s1 = i_prog_data;
    s_next.dat_s2 = s_reg.dat_s1;
    s_next.le_s1 = i_prog_latch;
    s_next.le_s2 = s_reg.le_s1;
    s_next.le_prev = s_reg.le_s2;
    s_next.valid = 1'b0;
    // msb first; the last 32 bits before the latch form the word
    if (s_reg.clk_s2 && !s_reg.clk_prev) begin
      s_next.shift = {s_reg.shift[coc_pkg::WORD_W-2:0], s_reg.dat_s2};
      if (s_reg.cnt != coc_pkg::BITCNT_MAX) begin
        s_next.cnt = s_reg.cnt + 6'h01;
      end
    end
    // a short word is dropped so a partial load never reaches the registers
    if (s_reg.le_s2 && !s_reg.le_prev) begin
      s_next.cnt = '0;
      if (s_reg.cnt >= coc_pkg::WORD_BITS) begin
        s_next.valid = 1'b1;
        s_next.word = s_reg.shift;
      end
    end
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_word.valid = s_reg.valid;
  assign o_word.word = s_reg.word;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_FULL_WORD_ONLY: assert property (
    @(posedge i_clk) disable iff (i_rst)
    s_reg.valid |-> ($past(s_reg.cnt) >= coc_pkg::WORD_BITS) && $past(s_reg.le_s2) && !$past(s_reg.le_prev)
  ) else $error("word handed over without a full word and a latch edge");

endmodule : coc_serial_rx

// file: coc_chan_div.sv
// one output channel: even-ratio divider or bypass of the distribution clock
`timescale 1ns/100ps
module coc_chan_div (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_dist_rise,
  input wire logic i_dist_level,
  input wire logic i_enable,
  input wire logic i_div_sel,
  input wire logic i_bypass_ok,
  input wire logic [coc_pkg::DIV_W-1:0] i_divide_code,
  output logic o_clk
);

  typedef struct packed {
    logic [coc_pkg::DIV_W-1:0] cnt;
    logic phase;
    logic out;
  } coc_div_s;

  coc_div_s s_reg;
  coc_div_s s_next;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  // disabled channels restart from zero so re-enabled channels come up aligned
  always_comb begin
    s_next = s_reg;
    if (!i_enable) begin
      s_next = '0;
    end else if (i_div_sel) begin
      if (i_divide_code == coc_pkg::DIV_INVALID) begin
        s_next = '0;
      end else begin
        // phase flips every code rising edges: total ratio is twice the code
        if (i_dist_rise) begin
          if (s_reg.cnt >= i_divide_code - 8'h01) begin
            s_next.cnt = '0;
            s_next.phase = ~s_reg.phase;
          end else begin
            s_next.cnt = s_reg.cnt + 8'h01;
          end
        end
        s_next.out = s_next.phase;
      end
    end else begin
      // bypass only for an even post-divide, otherwise held low
      s_next.cnt = '0;
      s_next.phase = 1'b0;
      s_next.out = i_bypass_ok & i_dist_level;
    end
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_clk = s_reg.out;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_DIV_ZERO_LOW: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_enable && i_div_sel && i_divide_code == coc_pkg::DIV_INVALID) |=> !o_clk
  ) else $error("divide code zero produced a clock");

  AST_BYPASS_ODD_LOW: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_enable && !i_div_sel && !i_bypass_ok) |=> !o_clk
  ) else $error("bypass passed clock with odd post-divide");

  AST_BYPASS_PASS: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_enable && !i_div_sel && i_bypass_ok) |=> (o_clk == $past(i_dist_level))
  ) else $error("bypass did not follow the distribution clock");

endmodule : coc_chan_div

// file: coc_prog_model.sv
// programming controller model driving the serial port
`timescale 1ns/100ps
module coc_prog_model (
  input wire logic i_clk,
  output logic o_prog_clk,
  output logic o_prog_data,
  output logic o_prog_latch
);
  initial begin
    o_prog_clk = 1'b0;
    o_prog_data = 1'b0;
    o_prog_latch = 1'b0;
  end
  // four cycles per level so the pin synchronisers never miss one
  task automatic hold4();
    repeat (4) @(posedge i_clk);
  endtask : hold4
  // shift low n bits msb first then latch; a full word is 32 bits
  task automatic send_bits(input logic [31:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      o_prog_clk <= 1'b0;
      o_prog_data <= w[i];
      hold4();
      o_prog_clk <= 1'b1;
      hold4();
    end
    o_prog_clk <= 1'b0;
    o_prog_data <= ~o_prog_data; // idle data must not keep the last bit
    hold4();
    o_prog_latch <= 1'b1;
    hold4();
    o_prog_latch <= 1'b0;
    hold4();
  endtask : send_bits
endmodule : coc_prog_model

// file: tb_top.sv
// self-checking bench for the clock output channel block
`timescale 1ns/100ps
module tb_top;
  logic clk, rst, gate_pin, dist_clk, p_clk, p_data, p_latch, all_on;
  logic [4:0] ch_out, drive, t_leg, t_oe, c_leg, c_oe, swing, dpath;
  logic [4:0][11:0] dly;
  logic [31:0] cfg [5];
  logic [31:0] w;
  logic [7:0] div_tab [4] = '{8'h01, 8'hff, 8'h00, 8'h05};
  logic [1:0] mux_tab [4] = '{2'h1, 2'h3, 2'h1, 2'h0};
  int mismatches, comparisons, seed, cyc, n;
  coc_prog_model prog (.i_clk(clk), .o_prog_clk(p_clk), .o_prog_data(p_data), .o_prog_latch(p_latch));
  coc_top dut (.i_clk(clk), .i_rst(rst), .i_prog_clk(p_clk), .i_prog_data(p_data), .i_prog_latch(p_latch),
    .i_global_output_gate_pin(gate_pin), .i_dist_clk(dist_clk), .o_output_channel(ch_out),
    .o_channel_drive(drive), .o_true_leg(t_leg), .o_true_leg_oe(t_oe), .o_comp_leg(c_leg),
    .o_comp_leg_oe(c_oe), .o_high_swing_pecl(swing), .o_delay_path_on(dpath), .o_channel_delay_ps(dly));
  // ----------------------------------------------------------------
  // clocks, timeout and helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // distribution clock at eight system cycles, slow enough to be sampled
  initial begin
    dist_clk = 1'b0;
    forever #160 dist_clk = ~dist_clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  function automatic logic [31:0] dflt(input int i);
    return 32'h0052_0000 | (i == 2 ? 32'h0001_0000 : 32'h0000_0000);
  endfunction : dflt
  function automatic logic [11:0] exp_dly(input logic [31:0] v);
    return v[18] ? 12'(v[7:4] * 150 + 300) : 12'h000;
  endfunction : exp_dly
  function automatic int exp_period(input logic [7:0] d, input logic [1:0] m);
    return !m[0] ? 8 : (d == 8'h00 ? 4999 : d * 16);
  endfunction : exp_period
  function automatic logic exp_leg(input logic [1:0] code, input logic on, input logic clk);
    return code[1] ? 1'b0 : on & (code[0] ? clk : ~clk);
  endfunction : exp_leg
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check
  task automatic check_all(input string s);
    for (int i = 0; i < 5; i++) begin
      check(drive[i], cfg[i][16] & all_on & gate_pin);
      check(dly[i], exp_dly(cfg[i]));
      check(swing[i], cfg[i][19]);
      check(dpath[i], cfg[i][18]);
      check(t_oe[i], cfg[i][23:22] != 2'h3);
      check(c_oe[i], cfg[i][21:20] != 2'h3);
      check(t_leg[i], exp_leg(cfg[i][23:22], cfg[i][16] & all_on & gate_pin, ch_out[i]));
      check(c_leg[i], exp_leg(cfg[i][21:20], cfg[i][16] & all_on & gate_pin, ch_out[i]));
    end
    $display("test %s done, mismatches %0d", s, mismatches);
  endtask : check_all
  task automatic wr(input logic [31:0] v);
    prog.send_bits(v, 32);
    repeat (8) @(posedge clk);
  endtask : wr
  // cycles between two rising edges of one channel, capped at 4999
  task automatic period(input int ch, output int k);
    for (int p = 0; p < 2; p++) begin
      k = 0;
      while (ch_out[ch] !== 1'b0 && k < 4999) begin
        @(posedge clk);
        k++;
      end
      while (ch_out[ch] !== 1'b1 && k < 4999) begin
        @(posedge clk);
        k++;
      end
    end
  endtask : period
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  // main sequence
  initial begin
    seed = 74028;
    mismatches = 0;
    comparisons = 0;
    cyc = 0;
    all_on = 1'b1;
    rst = 1'b1;
    gate_pin = 1'b1;
    for (int i = 0; i < 5; i++) cfg[i] = dflt(i);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    check_all("reset");
    period(2, n);
    check(n, 96);
    for (int k = 0; k < 4; k++) begin
      w = {8'h00, 2'h1, 2'h1, 1'b0, mux_tab[k], 1'b1, div_tab[k], 8'h00};
      wr(w);
      cfg[0] = w;
      period(0, n);
      check(n, exp_period(div_tab[k], mux_tab[k]));
    end
    wr(32'h00c0_000f);
    period(0, n);
    check(n, 4999);
    wr(32'h0080_000f);
    $display("test period done, mismatches %0d", mismatches);
    for (int k = 0; k < 20; k++) begin
      w = $random(seed);
      w[3:0] = 4'(k % 5);
      wr(w);
      cfg[k % 5] = w;
      check_all("random");
    end
    prog.send_bits(cfg[3] ^ 32'h0001_0000, 16);
    repeat (8) @(posedge clk);
    check_all("short word");
    wr(32'h0000_000d);
    all_on = 1'b0;
    check_all("global off");
    wr(32'h0004_000d);
    all_on = 1'b1;
    gate_pin <= 1'b0;
    w = {8'h00, 2'h1, 2'h1, 1'b0, 2'h1, 1'b1, 8'h02, 8'h01};
    wr(w);
    cfg[1] = w;
    check_all("gate low");
    check(ch_out, 5'h00);
    gate_pin <= 1'b1;
    repeat (8) @(posedge clk);
    check_all("gate high");
    wr(32'h0000_0007);
    check_all("no reset");
    wr(32'h0002_0007);
    for (int i = 0; i < 5; i++) cfg[i] = dflt(i);
    check_all("soft reset");
    period(2, n);
    check(n, 96);
    tally_and_finish();
  end
endmodule : tb_top
